// *** inc/fcb_defs.vh ***
/*
 * constants of the flash command bus controller: register offsets,
 * control field positions, flash command bytes and strobe timing.
 * assumes a 200 MHz clock and a byte-wide or word-wide flash part.
 */
`ifndef FCB_DEFS_VH
`define FCB_DEFS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------
`define FCB_REG_CTRL      8'h00
`define FCB_REG_ADDR      8'h04
`define FCB_REG_WDATA     8'h08
`define FCB_REG_RDATA     8'h0C
`define FCB_REG_STATUS    8'h10

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define FCB_CTRL_GO       0
`define FCB_CTRL_OP_LO    1
`define FCB_CTRL_OP_HI    3
`define FCB_CTRL_WIDE     4
`define FCB_CTRL_UNLOCK   5
`define FCB_CTRL_WPHIGH   6
`define FCB_CTRL_VPP      7
`define FCB_CTRL_PDOWN    8
`define FCB_CTRL_RESET    9'h000

// ----------------------------------------------------------------
// operation codes written to the op field
// ----------------------------------------------------------------
`define FCB_OP_READ       3'h0
`define FCB_OP_PROGRAM    3'h1
`define FCB_OP_ERASE      3'h2
`define FCB_OP_ID         3'h3
`define FCB_OP_STATUS     3'h4

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define FCB_ST_BUSY       0
`define FCB_ST_DONE       1
`define FCB_ST_READMODE   2
`define FCB_ST_FL_LO      8
`define FCB_ST_FL_HI      15

// ----------------------------------------------------------------
// flash command bytes
// ----------------------------------------------------------------
`define FCB_CMD_ERASE_ARM 8'h20
`define FCB_CMD_ERASE_GO  8'hD0
`define FCB_CMD_PROG_PREP 8'h40
`define FCB_CMD_PROG_ALT  8'h10
`define FCB_CMD_READ_ARR  8'hFF
`define FCB_CMD_ID_QUERY  8'h90
`define FCB_SR_READY_BIT  7

// ----------------------------------------------------------------
// strobe timing
// ----------------------------------------------------------------
`define FCB_CLK_NS        5
`define FCB_ACCESS_NS     80
`define FCB_WPULSE_NS     50
`define FCB_ACCESS_CYC    ((`FCB_ACCESS_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_WPULSE_CYC    ((`FCB_WPULSE_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
// strobe counter loads, one less than the cycle counts above
`define FCB_ACCESS_LOAD   5'h0F
`define FCB_WPULSE_LOAD   5'h09

`endif

// *** verilog/fcb_cycle.v ***
/*
 * one flash bus cycle: a single write or read on the flash pins with
 * chip select, output enable and write strobe timed from the clock.
 * assumes the flash samples write data on the rising write strobe.
 */
`timescale 1ns/1ps
`include "fcb_defs.vh"

module fcb_cycle (
	input  wire        clock,
	input  wire        srst,
	input  wire        start,
	input  wire        isWrite,
	input  wire        wide,
	input  wire [19:0] addrIn,
	input  wire [15:0] dataIn,
	input  wire [15:0] flDqIn,
	output reg  [19:0] flAddr,
	output reg  [15:0] flDqOut,
	output reg         flDqOe,
	output reg         flCeN,
	output reg         flOeN,
	output reg         flWeN,
	output reg  [15:0] rdData,
	output reg         done
);

	localparam [1:0] C_IDLE   = 2'h0;
	localparam [1:0] C_SETUP  = 2'h1;
	localparam [1:0] C_STROBE = 2'h2;
	localparam [1:0] C_HOLD   = 2'h3;

	reg [1:0] state_reg;
	reg [4:0] count_reg;
	reg       write_reg;

	// ----------------------------------------------------------------
	// cycle sequencer
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (srst) begin
			state_reg <= C_IDLE;
			count_reg <= 5'h0;
			write_reg <= 1'b0;
			flAddr    <= 20'h0_0000;
			flDqOut   <= 16'h0000;
			flDqOe    <= 1'b0;
			flCeN     <= 1'b1;
			flOeN     <= 1'b1;
			flWeN     <= 1'b1;
			rdData    <= 16'h0000;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_reg)
			C_IDLE: begin
				if (start) begin
					flAddr    <= addrIn;
					flDqOut   <= dataIn;
					write_reg <= isWrite;
					flDqOe    <= isWrite;
					flCeN     <= 1'b0;
					state_reg <= C_SETUP;
				end
			end
			C_SETUP: begin
				flWeN     <= ~write_reg;
				flOeN     <= write_reg;
				count_reg <= write_reg ? `FCB_WPULSE_LOAD :
				                         `FCB_ACCESS_LOAD;
				state_reg <= C_STROBE;
			end
			C_STROBE: begin
				if (count_reg == 5'h0) begin
					flWeN     <= 1'b1;
					flOeN     <= 1'b1;
					// upper lines dead in byte mode
					if (!write_reg)
						rdData <= wide ? flDqIn : {8'h00, flDqIn[7:0]};
					state_reg <= C_HOLD;
				end else begin
					count_reg <= count_reg - 5'h1;
				end
			end
			C_HOLD: begin
				flCeN     <= 1'b1;
				flDqOe    <= 1'b0;
				done      <= 1'b1;
				state_reg <= C_IDLE;
			end
			default: begin
				state_reg <= C_IDLE;
			end
			endcase
		end
	end

endmodule // fcb_cycle

// *** verilog/fcb_ctrl.v ***
/*
 * host-side controller for a block-erasable flash part: software
 * orders reads, programs, erases and id reads over a wishbone slave;
 * the controller runs the command sequences on the flash pins.
 * assumes the flash pins are wired directly and voltage switches for
 * unlock and program supply are driven from the control outputs.
 */
//
// Overview of operation
// - erase is arm byte then confirm
// - program is prepare byte then data
// - read-array command before array reads after operations
// - commands and status on low lines only
// - hold unlock or protect-high until done
`timescale 1ns/1ps
`include "fcb_defs.vh"

module fcb_ctrl (
	input  wire        clock,
	input  wire        srst,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	input  wire [15:0] flDqIn,
	output wire [19:0] flAddr,
	output wire [15:0] flDqOut,
	output wire        flDqOe,
	output wire        flCeN,
	output wire        flOeN,
	output wire        flWeN,
	output reg         resetPowerdownN,
	output reg         unlockVoltageOn,
	output reg         writeProtectHigh,
	output reg         progSupplyOn,
	output reg         flWordMode
);

	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_ARRAY = 3'h1;
	localparam [2:0] S_FIRST = 3'h2;
	localparam [2:0] S_SECND = 3'h3;
	localparam [2:0] S_POLL  = 3'h4;
	localparam [2:0] S_READ  = 3'h5;

	// ----------------------------------------------------------------
	// byte-lane merge of a register write
	// ----------------------------------------------------------------
	function [31:0] wbMerge;
		input [31:0] old;
		input [31:0] val;
		input [3:0]  sel;
		integer      i;
		begin
			wbMerge = old;
			for (i = 0; i < 4; i = i + 1)
				if (sel[i])
					wbMerge[i*8 +: 8] = val[i*8 +: 8];
		end
	endfunction

	reg  [8:0]  ctrl_reg;
	reg  [19:0] addr_reg;
	reg  [15:0] wdata_reg;
	reg  [15:0] rdata_reg;
	reg  [7:0]  flStat_reg;
	reg  [2:0]  op_reg;
	reg  [2:0]  state_reg;
	reg         busy_reg;
	reg         done_reg;
	reg         readMode_reg;
	reg         launched_reg;
	reg         cycStart_reg;
	reg         cycWrite_reg;
	reg  [19:0] cycAddr_reg;
	reg  [15:0] cycData_reg;
	wire [15:0] cycRdData;
	wire        cycDone;
	wire        wbReq;
	wire        wbWrite;
	wire        goReq;
	wire [31:0] ctrlMerged;
	wire [31:0] addrMerged;
	wire [31:0] wdataMerged;

	assign wbReq       = cyc_i & stb_i & ~ack_o;
	assign wbWrite     = wbReq & we_i;
	assign ctrlMerged  = wbMerge({23'h00_0000, ctrl_reg}, dat_i, sel_i);
	assign addrMerged  = wbMerge({12'h000, addr_reg}, dat_i, sel_i);
	assign wdataMerged = wbMerge({16'h0000, wdata_reg}, dat_i, sel_i);
	assign goReq = wbWrite & (adr_i == `FCB_REG_CTRL) & sel_i[0] &
	               dat_i[`FCB_CTRL_GO] & ~busy_reg;

	// ----------------------------------------------------------------
	// pin cycle engine
	// ----------------------------------------------------------------
	fcb_cycle uCycle (
		.clock   (clock),
		.srst    (srst),
		.start   (cycStart_reg),
		.isWrite (cycWrite_reg),
		.wide    (flWordMode),
		.addrIn  (cycAddr_reg),
		.dataIn  (cycData_reg),
		.flDqIn  (flDqIn),
		.flAddr  (flAddr),
		.flDqOut (flDqOut),
		.flDqOe  (flDqOe),
		.flCeN   (flCeN),
		.flOeN   (flOeN),
		.flWeN   (flWeN),
		.rdData  (cycRdData),
		.done    (cycDone)
	);

	// ----------------------------------------------------------------
	// wishbone slave: one wait state, unmapped reads give zero
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (srst) begin
			ack_o     <= 1'b0;
			dat_o     <= 32'h0000_0000;
			ctrl_reg  <= `FCB_CTRL_RESET;
			addr_reg  <= 20'h0_0000;
			wdata_reg <= 16'h0000;
		end else begin
			ack_o <= wbReq;
			if (wbReq && !we_i) begin
				case (adr_i)
				`FCB_REG_CTRL:   dat_o <= {23'h00_0000, ctrl_reg};
				`FCB_REG_ADDR:   dat_o <= {12'h000, addr_reg};
				`FCB_REG_WDATA:  dat_o <= {16'h0000, wdata_reg};
				`FCB_REG_RDATA:  dat_o <= {16'h0000, rdata_reg};
				`FCB_REG_STATUS: dat_o <= {16'h0000, flStat_reg, 5'h00,
				                  readMode_reg, done_reg, busy_reg};
				default:         dat_o <= 32'h0000_0000;
				endcase
			end
			if (wbWrite && !busy_reg) begin
				case (adr_i)
				`FCB_REG_CTRL:  ctrl_reg  <= {ctrlMerged[8:1], 1'b0};
				`FCB_REG_ADDR:  addr_reg  <= addrMerged[19:0];
				`FCB_REG_WDATA: wdata_reg <= wdataMerged[15:0];
				default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// pin levels from control register
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (srst) begin
			resetPowerdownN  <= 1'b1;
			unlockVoltageOn  <= 1'b0;
			writeProtectHigh <= 1'b0;
			progSupplyOn     <= 1'b0;
			flWordMode       <= 1'b0;
		end else begin
			resetPowerdownN  <= ~ctrl_reg[`FCB_CTRL_PDOWN];
			unlockVoltageOn  <= ctrl_reg[`FCB_CTRL_UNLOCK];
			writeProtectHigh <= ctrl_reg[`FCB_CTRL_WPHIGH];
			progSupplyOn     <= ctrl_reg[`FCB_CTRL_VPP];
			flWordMode       <= ctrl_reg[`FCB_CTRL_WIDE];
		end
	end

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (srst) begin
			state_reg    <= S_IDLE;
			op_reg       <= `FCB_OP_READ;
			busy_reg     <= 1'b0;
			done_reg     <= 1'b0;
			readMode_reg <= 1'b1;
			launched_reg <= 1'b0;
			cycStart_reg <= 1'b0;
			cycWrite_reg <= 1'b0;
			cycAddr_reg  <= 20'h0_0000;
			cycData_reg  <= 16'h0000;
			rdata_reg    <= 16'h0000;
			flStat_reg   <= 8'h00;
		end else begin
			cycStart_reg <= 1'b0;
			if (cycDone)
				launched_reg <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				// power-down returns device to read mode
				if (!resetPowerdownN) begin
					readMode_reg <= 1'b1;
					flStat_reg   <= 8'h00;
				end else if (goReq) begin
					op_reg   <= dat_i[`FCB_CTRL_OP_HI:`FCB_CTRL_OP_LO];
					busy_reg <= 1'b1;
					done_reg <= 1'b0;
					case (dat_i[`FCB_CTRL_OP_HI:`FCB_CTRL_OP_LO])
					`FCB_OP_READ:   state_reg <= readMode_reg ? S_READ
					                                           : S_ARRAY;
					`FCB_OP_STATUS: state_reg <= S_POLL;
					default:        state_reg <= S_FIRST;
					endcase
				end
			end
			S_ARRAY: begin
				if (!launched_reg) begin
					cycStart_reg <= 1'b1;
					cycWrite_reg <= 1'b1;
					cycAddr_reg  <= addr_reg;
					cycData_reg  <= {8'h00, `FCB_CMD_READ_ARR};
					launched_reg <= 1'b1;
				end else if (cycDone) begin
					readMode_reg <= 1'b1;
					state_reg    <= S_READ;
				end
			end
			S_FIRST: begin
				if (!launched_reg) begin
					cycStart_reg <= 1'b1;
					cycWrite_reg <= 1'b1;
					cycAddr_reg  <= addr_reg;
					case (op_reg)
					`FCB_OP_ERASE: cycData_reg <= {8'h00, `FCB_CMD_ERASE_ARM};
					`FCB_OP_ID:    cycData_reg <= {8'h00, `FCB_CMD_ID_QUERY};
					default:       cycData_reg <= {8'h00, `FCB_CMD_PROG_PREP};
					endcase
					launched_reg <= 1'b1;
				end else if (cycDone) begin
					readMode_reg <= 1'b0;
					state_reg    <= (op_reg == `FCB_OP_ID) ? S_READ : S_SECND;
				end
			end
			S_SECND: begin
				if (!launched_reg) begin
					cycStart_reg <= 1'b1;
					cycWrite_reg <= 1'b1;
					// erase confirm or program data at the full address from addr_reg
					cycAddr_reg  <= addr_reg;
					cycData_reg  <= (op_reg == `FCB_OP_ERASE) ?
					                {8'h00, `FCB_CMD_ERASE_GO} : wdata_reg;
					launched_reg <= 1'b1;
				end else if (cycDone) begin
					state_reg <= S_POLL;
				end
			end
			S_POLL: begin
				if (!launched_reg) begin
					// only status reads while engine busy
					cycStart_reg <= 1'b1;
					cycWrite_reg <= 1'b0;
					cycAddr_reg  <= addr_reg;
					launched_reg <= 1'b1;
				end else if (cycDone) begin
					flStat_reg <= cycRdData[7:0];
					if (cycRdData[`FCB_SR_READY_BIT] ||
					    op_reg == `FCB_OP_STATUS) begin
						busy_reg  <= 1'b0;
						done_reg  <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
			end
			S_READ: begin
				if (!launched_reg) begin
					cycStart_reg <= 1'b1;
					cycWrite_reg <= 1'b0;
					// a0 picks maker or device code
					cycAddr_reg  <= (op_reg == `FCB_OP_ID) ?
					                {19'h0_0000, addr_reg[0]} : addr_reg;
					launched_reg <= 1'b1;
				end else if (cycDone) begin
					rdata_reg <= cycRdData;
					busy_reg  <= 1'b0;
					done_reg  <= 1'b1;
					state_reg <= S_IDLE;
				end
			end
			default: begin
				state_reg <= S_IDLE;
			end
			endcase
		end
	end

endmodule // fcb_ctrl

// *** tb/fcb_ctrl_properties.sv ***
/* checker for the flash controller's bus and pins.
   bound to fcb_ctrl; sees its ports only. */
`timescale 1ns/1ps
module fcb_ctrl_props (
	input wire        clock,
	input wire        srst,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        we_i,
	input wire [7:0]  adr_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire [19:0] flAddr,
	input wire [15:0] flDqOut,
	input wire        flDqOe,
	input wire        flCeN,
	input wire        flOeN,
	input wire        flWeN,
	input wire        resetPowerdownN,
	input wire        unlockVoltageOn,
	input wire        writeProtectHigh
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// ten low cycles of write strobe, sixteen of output enable
	sequence s_weLow;
		!flWeN [*5] ##1 !flWeN [*5] ##1 flWeN;
	endsequence
	sequence s_oeLow;
		!flOeN [*8] ##1 !flOeN [*8] ##1 flOeN;
	endsequence
	a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack after request");
	a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without request");
	a_ack_one: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_unmapped_zero: assert property (
		ack_o && !we_i && adr_i > 8'h10 |-> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_ce_frame: assert property (!flWeN || !flOeN |-> !flCeN)
		else $error("strobe outside chip select");
	a_we_drive: assert property (!flWeN |-> flDqOe && flOeN)
		else $error("write without data drive");
	a_oe_quiet: assert property (!flOeN |-> !flDqOe && flWeN)
		else $error("data driven during read");
	a_we_len: assert property ($fell(flWeN) |-> s_weLow)
		else $error("write pulse length wrong");
	a_oe_len: assert property ($fell(flOeN) |-> s_oeLow)
		else $error("read pulse length wrong");
	a_pd_quiet: assert property (!resetPowerdownN |-> flCeN)
		else $error("cycle during power-down");
	a_we_stable: assert property (
		!flWeN && !$past(flWeN) |-> $stable(flDqOut) && $stable(flAddr))
		else $error("write data moved");
	a_unlock_hold: assert property (
		!flCeN |-> $stable(unlockVoltageOn) && $stable(writeProtectHigh))
		else $error("unlock level moved during a flash cycle");
endmodule // fcb_ctrl_props

bind fcb_ctrl fcb_ctrl_props u_props (.*);

// *** tb/fcb_flash_model.sv ***
/* behavioural flash part: 32 words, block 0 is the boot block.
   assumes strobes and pins from the controller. */
`timescale 1ns/1ps
module fcb_flash_model #(
	parameter [15:0] MAKER = 16'h00A5, // arbitrary value
	parameter [15:0] DEVID = 16'h005A  // arbitrary value
) (
	input  wire        ceN,
	input  wire        oeN,
	input  wire        weN,
	input  wire        rpN,
	input  wire        unlock,
	input  wire        wpHigh,
	input  wire        vpp,
	input  wire        hostOe,
	input  wire [19:0] addr,
	input  wire [15:0] dqIn,
	output wire [15:0] dqOut,
	output wire        dqOe,
	output reg         clash
);
	// ----------------------------------------
	// array, decoder and status
	// ----------------------------------------
	reg  [15:0] mem [0:31];
	reg  [1:0]  mode;
	reg  [1:0]  pend;
	reg  [7:0]  st, nRd, rdBase;
	wire [7:0]  cmd = dqIn[7:0];
	wire        ready = (nRd - rdBase) >= 8'h02;
	wire        okBlk = addr[4] | unlock | wpHigh;
	wire [15:0] rdVal = (mode == 2'h0) ? mem[addr[4:0]] :
		(mode == 2'h1) ? (addr[0] ? DEVID : MAKER) :
		{8'h00, st | {ready, 7'h00}};
	integer     i;
	initial begin
		for (i = 0; i < 32; i = i + 1)
			mem[i] = 16'hFFFF;
		{mode, pend, st, nRd, rdBase, clash} = 0;
	end
	// drive only in reads, released lines wander
	assign dqOe = !ceN && !oeN && weN && rpN;
	assign dqOut = dqOe ? rdVal : ~rdVal;
	always @(posedge oeN)
		nRd <= nRd + 8'h01;
	always @(posedge (dqOe & hostOe))
		clash <= 1'b1;
	always @(posedge weN or negedge rpN) begin
		if (!rpN) begin
			{mode, pend, st} <= 0;
		end else if (!ceN) begin
			rdBase <= nRd;
			pend <= 2'h0;
			if (pend != 2'h0)
				mode <= 2'h2;
			else if (cmd == 8'hFF)
				mode <= 2'h0;
			else if (cmd == 8'h90)
				mode <= 2'h1;
			else if (cmd == 8'h20 || cmd == 8'h40 || cmd == 8'h10) begin
				mode <= 2'h2;
				pend <= (cmd == 8'h20) ? 2'h2 : 2'h1;
			end
			if (pend == 2'h1 && vpp && okBlk)
				mem[addr[4:0]] <= dqIn;
			else if (pend == 2'h1)
				st <= st | (vpp ? 8'h10 : 8'h18);
			if (pend == 2'h2 && cmd == 8'hD0 && vpp && okBlk) begin
				for (i = 0; i < 32; i = i + 1)
					if (i[4] == addr[4])
						mem[i] <= 16'hFFFF;
			end else if (pend == 2'h2 && cmd == 8'hD0)
				st <= st | 8'h20;
		end
	end
endmodule // fcb_flash_model

// *** tb/tb_top.sv ***
/* bench for fcb_ctrl with the flash model.
   assumes a 200 MHz clock and one clock domain. */
`timescale 1ns/1ps
`include "fcb_defs.vh"
module tb_top;
	// ----------------------------------------
	// wiring
	// ----------------------------------------
	reg         clock, srst, cyc, stb, we;
	reg  [7:0]  adr;
	reg  [31:0] dat, q;
	wire [31:0] datO;
	wire        ack, flDqOe, ceN, oeN, weN, rpN, unl, wp, vpp;
	wire        wide, mOe, clash;
	wire [19:0] flAddr;
	wire [15:0] flDqOut, mDq, flDqIn;
	integer     n_errors, n_checks;
	localparam [31:0] CF = 32'h0000_0091;
	assign flDqIn = flDqOe ? flDqOut : mDq;
	fcb_ctrl dut_u (.clock(clock), .srst(srst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
		.dat_i(dat), .dat_o(datO), .ack_o(ack), .flDqIn(flDqIn),
		.flAddr(flAddr), .flDqOut(flDqOut), .flDqOe(flDqOe),
		.flCeN(ceN), .flOeN(oeN), .flWeN(weN),
		.resetPowerdownN(rpN), .unlockVoltageOn(unl),
		.writeProtectHigh(wp), .progSupplyOn(vpp), .flWordMode(wide));
	fcb_flash_model fm_u (.ceN(ceN), .oeN(oeN), .weN(weN),
		.rpN(rpN), .unlock(unl), .wpHigh(wp), .vpp(vpp),
		.hostOe(flDqOe), .addr(flAddr), .dqIn(flDqIn), .dqOut(mDq),
		.dqOe(mOe), .clash(clash));
	// one classic wishbone cycle, result in q
	task bus(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge clock);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			dat <= d;
			@(posedge clock);
			while (ack !== 1'b1)
				@(posedge clock);
			q = datO;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
		begin
			n_checks = n_checks + 1;
			if (s !== e) begin
				n_errors = n_errors + 1;
				$display("[ERR] %0s exp %h got %h", nm, e, s);
			end
		end
	endtask
	// start an operation and poll until done; q keeps status
	task runOp(input [31:0] c, input [19:0] a, input [15:0] d);
		begin
			bus(1'b1, `FCB_REG_ADDR, {12'h000, a});
			bus(1'b1, `FCB_REG_WDATA, {16'h0000, d});
			bus(1'b1, `FCB_REG_CTRL, c);
			q = 32'h0000_0000;
			while (q[`FCB_ST_DONE] !== 1'b1)
				bus(1'b0, `FCB_REG_STATUS, 32'h0000_0000);
		end
	endtask
	task rdOp(input [31:0] c, input [19:0] a, input [31:0] e);
		begin
			runOp(c, a, 16'h0000);
			bus(1'b0, `FCB_REG_RDATA, 32'h0000_0000);
			chk("rdata", e, q);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		begin
			bus(1'b0, `FCB_REG_STATUS, 32'h0000_0000);
			chk("busy", 32'h0, q & 32'h3);
			bus(1'b0, 8'h20, 32'h0000_0000);
			chk("unmap", 32'h0, q);
			bus(1'b1, `FCB_REG_CTRL, 32'h0000_0090);
			rdOp(CF, 20'h00001, 32'h0000_FFFF);
			chk("wide", 32'h1, {31'h0, wide});
			$display("t_reset done");
		end
	endtask
	task t_prog;
		begin
			runOp(CF | 32'h2, 20'h00011, 16'h1234);
			chk("fstat", 32'h80, q[15:8]);
			rdOp(CF, 20'h00011, 32'h0000_1234);
			runOp(CF | 32'h42, 20'h00002, 16'h5678);
			rdOp(CF, 20'h00002, 32'h0000_5678);
			$display("t_prog done");
		end
	endtask
	task t_erase;
		begin
			runOp(CF | 32'h4, 20'h00003, 16'h0000);
			chk("fstat", 32'hA0, q[15:8]);
			rdOp(CF, 20'h00002, 32'h0000_5678);
			runOp(CF | 32'h24, 20'h00003, 16'h0000);
			rdOp(CF, 20'h00002, 32'h0000_FFFF);
			rdOp(CF, 20'h00011, 32'h0000_1234);
			$display("t_erase done");
		end
	endtask
	task t_id;
		begin
			rdOp(CF | 32'h6, 20'h00000, 32'h0000_00A5);
			rdOp(CF | 32'h6, 20'h00001, 32'h0000_005A);
			// byte bus: upper lines read as zero
			rdOp(32'h0000_0081, 20'h00011, 32'h0000_0034);
			$display("t_id done");
		end
	endtask
	task t_pdown;
		begin
			bus(1'b1, `FCB_REG_CTRL, 32'h0000_0190);
			bus(1'b0, `FCB_REG_STATUS, 32'h0000_0000);
			chk("rpin", 32'h0, {31'h0, rpN});
			chk("rdmode", 32'h1, q[2]);
			bus(1'b1, `FCB_REG_CTRL, 32'h0000_0090);
			// power-down left the part in array mode with status cleared
			runOp(CF | 32'h2, 20'h00012, 16'hBEEF);
			chk("fstat", 32'h80, q[15:8]);
			runOp(CF | 32'h8, 20'h00012, 16'h0000);
			chk("fstat", 32'h80, q[15:8]);
			rdOp(CF, 20'h00012, 32'h0000_BEEF);
			chk("clash", 32'h0, {31'h0, clash});
			$display("t_pdown done");
		end
	endtask
	// ----------------------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		srst = 1'b1;
		{cyc, stb, we, adr, dat, q} = 0;
		n_errors = 0;
		n_checks = 0;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		t_reset;
		t_prog;
		t_erase;
		t_id;
		t_pdown;
		finish_test;
	end
	initial begin
		#200000;
		n_errors = n_errors + 1;
		finish_test;
	end
endmodule // tb_top
